//--- src/sld_pattern_gen.sv
// Free-running blink pattern generator for the status LEDs.
// Assumes one clock; every pattern steps on a common tick enable.
`timescale 1ns/1ps
`default_nettype none
module sld_pattern_gen #(
	parameter int TICK_CYCLES = sld_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Patterns
	output logic slow_q,
	output logic fast_q,
	output logic single_q,
	output logic double_q
);
	logic [22:0] div_q;
	logic tick;
	logic [3:0] slow_cnt_q;
	logic [3:0] fast_cnt_q;
	logic [5:0] single_cnt_q;
	logic [5:0] double_cnt_q;

	assign tick = (div_q == 23'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 23'h000000;
		end else if (tick) begin
			div_q <= 23'h000000;
		end else begin
			div_q <= div_q + 23'h000001;
		end
	end

	// All patterns share one tick so their phases never drift apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cnt_q <= 4'h0;
			slow_q <= 1'b1;
			fast_cnt_q <= 4'h0;
			fast_q <= 1'b1;
		end else if (tick) begin
			if (slow_cnt_q == 4'(sld_pkg::SLOW_HALF_TICKS - 1)) begin
				slow_cnt_q <= 4'h0;
				slow_q <= ~slow_q;
			end else begin
				slow_cnt_q <= slow_cnt_q + 4'h1;
			end
			if (fast_cnt_q == 4'(sld_pkg::FAST_HALF_TICKS - 1)) begin
				fast_cnt_q <= 4'h0;
				fast_q <= ~fast_q;
			end else begin
				fast_cnt_q <= fast_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_cnt_q <= 6'h00;
			double_cnt_q <= 6'h00;
		end else if (tick) begin
			single_cnt_q <= (single_cnt_q == 6'(sld_pkg::SINGLE_PERIOD_TICKS - 1)) ?
				6'h00 : single_cnt_q + 6'h01;
			double_cnt_q <= (double_cnt_q == 6'(sld_pkg::DOUBLE_PERIOD_TICKS - 1)) ?
				6'h00 : double_cnt_q + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_q <= 1'b0;
			double_q <= 1'b0;
		end else begin
			single_q <= (single_cnt_q < 6'(sld_pkg::PULSE_ON_TICKS));
			double_q <= (double_cnt_q < 6'(sld_pkg::PULSE_ON_TICKS)) ||
				((double_cnt_q >= 6'(sld_pkg::PULSE_ON_TICKS + sld_pkg::PULSE_GAP_TICKS)) &&
				(double_cnt_q < 6'(2 * sld_pkg::PULSE_ON_TICKS + sld_pkg::PULSE_GAP_TICKS)));
		end
	end
endmodule
`default_nettype wire

//--- src/sld_pkg.sv
// Shared constants and types of the status LED driver.
// Assumes a single 125 MHz clock; all blink timing is counted in fixed ticks.
package sld_pkg;
	// Clock and pattern timing
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_MS = 50;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
	localparam int SLOW_HALF_MS = 200;
	localparam int FAST_HALF_MS = 50;
	localparam int PULSE_ON_MS = 200;
	localparam int PULSE_GAP_MS = 200;
	localparam int PULSE_OFF_MS = 1000;
	localparam int SLOW_HALF_TICKS = SLOW_HALF_MS / TICK_MS;
	localparam int FAST_HALF_TICKS = FAST_HALF_MS / TICK_MS;
	localparam int PULSE_ON_TICKS = PULSE_ON_MS / TICK_MS;
	localparam int PULSE_GAP_TICKS = PULSE_GAP_MS / TICK_MS;
	localparam int SINGLE_PERIOD_TICKS = (PULSE_ON_MS + PULSE_OFF_MS) / TICK_MS;
	localparam int DOUBLE_PERIOD_TICKS = (2 * PULSE_ON_MS + PULSE_GAP_MS + PULSE_OFF_MS) / TICK_MS;

	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CHDIR = 8'h04;
	localparam logic [7:0] OFF_LEDSTAT = 8'h08;
	localparam logic [7:0] OFF_CHSTAT = 8'h0c;
	localparam logic [7:0] OFF_SWITCH = 8'h10;

	// Reset values
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam logic [15:0] CHDIR_RST = 16'h0000;

	// Control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;

	// Switch code limits
	localparam logic [3:0] SW_UNITS_MAX = 4'h9;
	localparam logic [7:0] SW_CODE_MAX = 8'h9f;

	// Channel layout
	localparam int NUM_CHAN = 16;
	localparam int CHAN_PER_BYTE = 8;

	typedef enum logic [3:0] {
		SLD_ESM_INIT = 4'b0001,
		SLD_ESM_PREOP = 4'b0010,
		SLD_ESM_BOOT = 4'b0011,
		SLD_ESM_SAFEOP = 4'b0100,
		SLD_ESM_OP = 4'b1000
	} sld_esm_t;

	typedef enum logic [2:0] {
		SLD_RDY_OFF = 3'b000,
		SLD_RDY_GREEN = 3'b001,
		SLD_RDY_FW = 3'b010,
		SLD_RDY_ALT = 3'b011,
		SLD_RDY_RED = 3'b100
	} sld_rdy_t;

	typedef enum logic [2:0] {
		SLD_ERR_NONE = 3'b000,
		SLD_ERR_APP = 3'b001,
		SLD_ERR_CFG = 3'b010,
		SLD_ERR_WDOG = 3'b011,
		SLD_ERR_CRIT = 3'b100
	} sld_err_t;
endpackage

//--- src/sld_top.sv
// Status LED driver top: maps device conditions to LED light patterns, APB registers.
// Assumes status inputs synchronous to pclk; LED outputs drive lamps directly, high = lit.
// Contract
// - Link LED green while upstream or downstream port has a connection.
// - Readiness LED steady green when ready, dark when not ready.
// - Readiness LED flashes yellow during firmware update.
// - Readiness LED alternates green/yellow on supply fault or critical temperature.
// - Sensor overload: readiness alternates green/yellow and sensor supply LED red.
// - Readiness LED steady red when rotary switches are invalid or reserved.
// - Run LED dark in Init state.
// - Run LED blinks green at 2.5 Hz in Pre-Operational.
// - Run LED single pulse, 200 ms on, 1000 ms off, in Safe-Operational.
// - Run LED steady green in Operational.
// - Run LED blinks at 10 Hz in Bootstrap.
// - Fault LED steady red on critical error, dark when no error.
// - Fault LED blinks at 2.5 Hz on configuration error.
// - Fault LED single pulse on local application error.
// - Fault LED double pulse on process data watchdog expiry.
// - Sensor supply LED green while sensor voltage present, else dark.
// - Sensor supply LED steady red while sensor voltage overloaded.
// - Drive power LED green while actuator voltage present.
// - Input channel LED yellow while input set, else dark.
// - Output channel LED yellow when set, red when shorted, else dark.
// - Channel LEDs indexed byte then bit, sixteen channels in data order.
`timescale 1ns/1ps
`default_nettype none
module sld_top #(
	parameter int TICK_CYCLES = sld_pkg::TICK_CYCLES,
	parameter int NUM_CHAN = sld_pkg::NUM_CHAN
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Network and device status
	input wire logic upstream_port_link,
	input wire logic downstream_port_link,
	input wire logic dev_ready,
	input wire logic fw_update,
	input wire logic temp_critical,
	input wire logic [3:0] esm_state,
	input wire logic err_critical,
	input wire logic err_config,
	input wire logic err_app,
	input wire logic err_watchdog,
	// Rotary identification switches, tens and units
	input wire logic [3:0] switch_tens,
	input wire logic [3:0] switch_units,
	// Supply monitors
	input wire logic sensor_supply_ok,
	input wire logic sensor_supply_range_fault,
	input wire logic sensor_supply_overload,
	input wire logic actuator_supply_ok,
	// Channel status, index byte*8+bit
	input wire logic [NUM_CHAN-1:0] chan_set,
	input wire logic [NUM_CHAN-1:0] chan_fault,
	// LED drives
	output logic link_led_green,
	output logic ready_led_green,
	output logic ready_led_yellow,
	output logic ready_led_red,
	output logic run_led_green,
	output logic fault_led_red,
	output logic sensor_supply_led_green,
	output logic sensor_supply_led_red,
	output logic drive_power_led_green,
	output logic [NUM_CHAN-1:0] chan_led_yellow,
	output logic [NUM_CHAN-1:0] chan_led_red
);
	logic slow;
	logic fast;
	logic single;
	logic double;
	logic [1:0] ctrl_q;
	logic [NUM_CHAN-1:0] chdir_q;
	logic [7:0] sw_code_q;
	logic sw_valid_q;
	logic sw_taken_q;
	logic [7:0] sw_code;
	logic sw_valid;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] rdata;
	logic leds_on;
	logic test_on;
	sld_pkg::sld_rdy_t rdy_sel;
	sld_pkg::sld_err_t err_sel;
	logic rdy_g;
	logic rdy_y;
	logic rdy_r;
	logic run_d;
	logic err_d;
	logic us_g;
	logic us_r;
	logic [NUM_CHAN-1:0] ch_y;
	logic [NUM_CHAN-1:0] ch_r;

	sld_pattern_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_pattern (
		.pclk(pclk),
		.presetn(presetn),
		.slow_q(slow),
		.fast_q(fast),
		.single_q(single),
		.double_q(double)
	);

	// APB slave: zero wait states, error on unmapped or read-only write
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	// Read data loads at the setup edge so the flop already stands when the access completes
	assign rd_en = psel && !penable && !pwrite;

	always_comb begin
		addr_ok = 1'b1;
		rdata = 32'h00000000;
		unique case (paddr)
			sld_pkg::OFF_CTRL: begin
				rdata = {30'h00000000, ctrl_q};
			end
			sld_pkg::OFF_CHDIR: begin
				rdata = 32'(chdir_q);
			end
			sld_pkg::OFF_LEDSTAT: begin
				rdata = {23'h000000, drive_power_led_green, sensor_supply_led_red,
					sensor_supply_led_green, fault_led_red, run_led_green,
					ready_led_red, ready_led_yellow, ready_led_green, link_led_green};
			end
			sld_pkg::OFF_CHSTAT: begin
				rdata = {16'(chan_led_red), 16'(chan_led_yellow)};
			end
			sld_pkg::OFF_SWITCH: begin
				rdata = {23'h000000, sw_valid_q, sw_code_q};
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	assign pslverr = psel && penable && (!addr_ok ||
		(pwrite && paddr != sld_pkg::OFF_CTRL && paddr != sld_pkg::OFF_CHDIR));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= sld_pkg::CTRL_RST;
		end else if (wr_en && paddr == sld_pkg::OFF_CTRL) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chdir_q <= NUM_CHAN'(sld_pkg::CHDIR_RST);
		end else if (wr_en && paddr == sld_pkg::OFF_CHDIR) begin
			chdir_q <= pwdata[NUM_CHAN-1:0];
		end
	end

	// Switch code = tens*10 + units; changes only take effect after a reset
	assign sw_code = 8'({4'h0, switch_tens} * 8'h0a) + {4'h0, switch_units};
	assign sw_valid = (switch_units <= sld_pkg::SW_UNITS_MAX) && (sw_code != 8'h00) &&
		(sw_code <= sld_pkg::SW_CODE_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_taken_q <= 1'b0;
			sw_code_q <= 8'h00;
			sw_valid_q <= 1'b1;
		end else if (!sw_taken_q) begin
			sw_taken_q <= 1'b1;
			sw_code_q <= sw_code;
			sw_valid_q <= sw_valid;
		end
	end

	assign test_on = ctrl_q[sld_pkg::CTRL_TEST_BIT];
	assign leds_on = ctrl_q[sld_pkg::CTRL_EN_BIT];

	// Readiness: invalid switch worst, then supply/thermal faults, then update
	always_comb begin
		if (sw_taken_q && !sw_valid_q) begin
			rdy_sel = sld_pkg::SLD_RDY_RED;
		end else if (sensor_supply_overload || sensor_supply_range_fault || temp_critical) begin
			rdy_sel = sld_pkg::SLD_RDY_ALT;
		end else if (fw_update) begin
			rdy_sel = sld_pkg::SLD_RDY_FW;
		end else if (dev_ready) begin
			rdy_sel = sld_pkg::SLD_RDY_GREEN;
		end else begin
			rdy_sel = sld_pkg::SLD_RDY_OFF;
		end
	end

	always_comb begin
		rdy_g = 1'b0;
		rdy_y = 1'b0;
		rdy_r = 1'b0;
		unique case (rdy_sel)
			sld_pkg::SLD_RDY_OFF: begin
				rdy_g = 1'b0;
			end
			sld_pkg::SLD_RDY_GREEN: begin
				rdy_g = 1'b1;
			end
			sld_pkg::SLD_RDY_FW: begin
				rdy_y = slow;
			end
			sld_pkg::SLD_RDY_ALT: begin
				rdy_g = slow;
				rdy_y = ~slow;
			end
			sld_pkg::SLD_RDY_RED: begin
				rdy_r = 1'b1;
			end
		endcase
	end

	// Run LED follows the slave state machine; unknown codes stay dark
	always_comb begin
		unique case (esm_state)
			sld_pkg::SLD_ESM_INIT: begin
				run_d = 1'b0;
			end
			sld_pkg::SLD_ESM_PREOP: begin
				run_d = slow;
			end
			sld_pkg::SLD_ESM_SAFEOP: begin
				run_d = single;
			end
			sld_pkg::SLD_ESM_OP: begin
				run_d = 1'b1;
			end
			sld_pkg::SLD_ESM_BOOT: begin
				run_d = fast;
			end
			default: begin
				run_d = 1'b0;
			end
		endcase
	end

	// Fault: critical over watchdog over configuration over application
	always_comb begin
		if (err_critical) begin
			err_sel = sld_pkg::SLD_ERR_CRIT;
		end else if (err_watchdog) begin
			err_sel = sld_pkg::SLD_ERR_WDOG;
		end else if (err_config) begin
			err_sel = sld_pkg::SLD_ERR_CFG;
		end else if (err_app) begin
			err_sel = sld_pkg::SLD_ERR_APP;
		end else begin
			err_sel = sld_pkg::SLD_ERR_NONE;
		end
	end

	always_comb begin
		err_d = 1'b0;
		unique case (err_sel)
			sld_pkg::SLD_ERR_NONE: begin
				err_d = 1'b0;
			end
			sld_pkg::SLD_ERR_APP: begin
				err_d = single;
			end
			sld_pkg::SLD_ERR_CFG: begin
				err_d = slow;
			end
			sld_pkg::SLD_ERR_WDOG: begin
				err_d = double;
			end
			sld_pkg::SLD_ERR_CRIT: begin
				err_d = 1'b1;
			end
		endcase
	end

	// Red overrides green so an overloaded supply never looks healthy
	assign us_r = sensor_supply_overload;
	assign us_g = sensor_supply_ok && !sensor_supply_overload;

	// Channel index c = byte*8 + bit matches the process data bit order
	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c = c + 1) begin : g_chan
			always_comb begin
				if (chdir_q[c]) begin
					ch_r[c] = chan_fault[c];
					ch_y[c] = chan_set[c] && !chan_fault[c];
				end else begin
					ch_r[c] = 1'b0;
					ch_y[c] = chan_set[c];
				end
			end
		end
	endgenerate

	// Lamp test lights every segment even when disabled; disable without lamp test darkens all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_led_green <= 1'b0;
			ready_led_green <= 1'b0;
			ready_led_yellow <= 1'b0;
			ready_led_red <= 1'b0;
			run_led_green <= 1'b0;
			fault_led_red <= 1'b0;
		end else if (test_on) begin
			link_led_green <= 1'b1;
			ready_led_green <= 1'b1;
			ready_led_yellow <= 1'b1;
			ready_led_red <= 1'b1;
			run_led_green <= 1'b1;
			fault_led_red <= 1'b1;
		end else begin
			link_led_green <= leds_on && (upstream_port_link || downstream_port_link);
			ready_led_green <= leds_on && rdy_g;
			ready_led_yellow <= leds_on && rdy_y;
			ready_led_red <= leds_on && rdy_r;
			run_led_green <= leds_on && run_d;
			fault_led_red <= leds_on && err_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sensor_supply_led_green <= 1'b0;
			sensor_supply_led_red <= 1'b0;
			drive_power_led_green <= 1'b0;
			chan_led_yellow <= '0;
			chan_led_red <= '0;
		end else if (test_on) begin
			sensor_supply_led_green <= 1'b1;
			sensor_supply_led_red <= 1'b1;
			drive_power_led_green <= 1'b1;
			chan_led_yellow <= '1;
			chan_led_red <= '1;
		end else begin
			sensor_supply_led_green <= leds_on && us_g;
			sensor_supply_led_red <= leds_on && us_r;
			drive_power_led_green <= leds_on && actuator_supply_ok;
			chan_led_yellow <= leds_on ? ch_y : '0;
			chan_led_red <= leds_on ? ch_r : '0;
		end
	end
endmodule
`default_nettype wire

//--- verification/sld_led_observer.sv
// Lamp observer standing in for the operator who watches one LED.
// Assumes the lamp is sampled on the system clock; lengths count in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module sld_led_observer (
	// Sampling clock and watched lamp
	input wire logic clk,
	input wire logic led,
	// Last complete lit and dark stretch
	output var int hi_len,
	output var int lo_len
);
	int cnt = 0;
	logic last = 1'b0;

	// A stretch is only reported once it ends, so partial ones never count
	always @(posedge clk) begin
		if (led !== last) begin
			if (last === 1'b1)
				hi_len <= cnt;
			else
				lo_len <= cnt;
			cnt <= 1;
		end else
			cnt <= cnt + 1;
		last <= led;
	end
endmodule
`default_nettype wire

//--- verification/sld_monitor.sv
// Lamp checker for the status LED driver, bound to its top.
// Assumes lamps follow their inputs one edge later while CTRL is plain enable.
`timescale 1ns/1ps
`default_nettype none
module sld_monitor #(
	parameter int TICK_CYCLES = 10
) (
	// Clock, reset and register writes
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// Conditions
	input wire logic upstream_port_link,
	input wire logic downstream_port_link,
	input wire logic [3:0] esm_state,
	input wire logic err_critical,
	input wire logic temp_critical,
	input wire logic sensor_supply_ok,
	input wire logic sensor_supply_range_fault,
	input wire logic sensor_supply_overload,
	input wire logic actuator_supply_ok,
	// Lamps
	input wire logic link_led_green,
	input wire logic ready_led_green,
	input wire logic ready_led_yellow,
	input wire logic ready_led_red,
	input wire logic run_led_green,
	input wire logic fault_led_red,
	input wire logic sensor_supply_led_green,
	input wire logic sensor_supply_led_red,
	input wire logic drive_power_led_green
);
	logic [1:0] ctrl_q;
	logic prev_q;
	logic [1:0] live_q;
	logic ok;

	// Shadow of CTRL: lamp test or disable must silence every check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 2'h1;
			prev_q <= 1'b0;
			live_q <= 2'h0;
		end else begin
			if (psel && penable && pwrite && paddr == 8'h00)
				ctrl_q <= pwdata[1:0];
			prev_q <= ctrl_q == 2'h1;
			if (live_q != 2'h3)
				live_q <= live_q + 2'h1;
		end
	end
	assign ok = live_q[1] && prev_q && ctrl_q == 2'h1;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_op_held;
		esm_state == 4'h8 ##1 ok;
	endsequence
	sequence s_init_held;
		esm_state == 4'h1 ##1 ok;
	endsequence

	a_link_follows_ports: assert property (
		ok |-> link_led_green == $past(upstream_port_link || downstream_port_link))
		else $error("link lamp wrong");
	a_sensor_red_overload: assert property (
		ok |-> sensor_supply_led_red == $past(sensor_supply_overload))
		else $error("sensor red lamp wrong");
	a_sensor_green_present: assert property (
		ok && $past(sensor_supply_ok && !sensor_supply_overload) |-> sensor_supply_led_green)
		else $error("sensor green lamp wrong");
	a_drive_follows_supply: assert property (
		ok |-> drive_power_led_green == $past(actuator_supply_ok))
		else $error("drive lamp wrong");
	a_run_init_dark: assert property (s_init_held |-> !run_led_green)
		else $error("run lamp lit in init");
	a_run_op_steady: assert property (s_op_held |-> run_led_green)
		else $error("run lamp dark in operational");
	a_fault_critical_lit: assert property (err_critical ##1 ok |-> fault_led_red)
		else $error("fault lamp dark on critical error");
	a_ready_alarm_alternates: assert property (
		ok && !ready_led_red
		&& $past(sensor_supply_overload || sensor_supply_range_fault || temp_critical)
		|-> ready_led_green != ready_led_yellow)
		else $error("ready lamp not alternating");
endmodule

bind sld_top sld_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .upstream_port_link(upstream_port_link),
	.downstream_port_link(downstream_port_link), .esm_state(esm_state),
	.err_critical(err_critical), .temp_critical(temp_critical),
	.sensor_supply_ok(sensor_supply_ok), .sensor_supply_range_fault(sensor_supply_range_fault),
	.sensor_supply_overload(sensor_supply_overload), .actuator_supply_ok(actuator_supply_ok),
	.link_led_green(link_led_green), .ready_led_green(ready_led_green),
	.ready_led_yellow(ready_led_yellow), .ready_led_red(ready_led_red),
	.run_led_green(run_led_green), .fault_led_red(fault_led_red),
	.sensor_supply_led_green(sensor_supply_led_green),
	.sensor_supply_led_red(sensor_supply_led_red),
	.drive_power_led_green(drive_power_led_green));
`default_nettype wire

//--- verification/sld_top_tb.sv
// Self-checking bench for the status LED driver top.
// Assumes a short tick so that blink stretches are tens of cycles long.
`timescale 1ns/1ps
`default_nettype none
module sld_top_tb;
	localparam int TK = 10;
	localparam logic [3:0] RC[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
	localparam int RH[5] = '{0, 4*TK, TK, 4*TK, 1};
	localparam int RL[5] = '{0, 4*TK, TK, 20*TK, 0};
	localparam logic [3:0] FV[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
	localparam int FH[6] = '{0, 4*TK, 4*TK, 4*TK, 1, 1};
	localparam int FL[6] = '{0, 20*TK, 4*TK, -1, 0, 0};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic up = 1'b0, dn = 1'b0, rdy = 1'b0, fw = 1'b0, tmp = 1'b0, crit = 1'b0, cfg = 1'b0;
	logic app = 1'b0, wd = 1'b0, s_ok = 1'b0, s_rng = 1'b0, s_ovl = 1'b0, a_ok = 1'b0;
	logic [3:0] esm = 4'h1, sw_t = 4'h1, sw_u = 4'h2;
	logic [15:0] cset = 16'h0, cflt = 16'h0, cy, cr;
	logic l_lnk, r_g, r_y, r_r, l_run, l_flt, u_g, u_r, d_g;
	int errors = 0, tests_run = 0, run_hi, run_lo, flt_hi, flt_lo, yel_hi, yel_lo;

	always #4 pclk = ~pclk;

	sld_top #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .upstream_port_link(up), .downstream_port_link(dn),
		.dev_ready(rdy), .fw_update(fw), .temp_critical(tmp), .esm_state(esm),
		.err_critical(crit), .err_config(cfg), .err_app(app), .err_watchdog(wd),
		.switch_tens(sw_t), .switch_units(sw_u), .sensor_supply_ok(s_ok),
		.sensor_supply_range_fault(s_rng), .sensor_supply_overload(s_ovl),
		.actuator_supply_ok(a_ok), .chan_set(cset), .chan_fault(cflt), .link_led_green(l_lnk),
		.ready_led_green(r_g), .ready_led_yellow(r_y), .ready_led_red(r_r),
		.run_led_green(l_run), .fault_led_red(l_flt), .sensor_supply_led_green(u_g),
		.sensor_supply_led_red(u_r), .drive_power_led_green(d_g), .chan_led_yellow(cy),
		.chan_led_red(cr));
	sld_led_observer o_run (.clk(pclk), .led(l_run), .hi_len(run_hi), .lo_len(run_lo));
	sld_led_observer o_flt (.clk(pclk), .led(l_flt), .hi_len(flt_hi), .lo_len(flt_lo));
	sld_led_observer o_yel (.clk(pclk), .led(r_y), .hi_len(yel_hi), .lo_len(yel_lo));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Settle past the edge so lamp updates of that edge have landed
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// Read data stands through the access phase and is taken at the edge that completes it
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		er = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			errors++;
			stop_test();
		end
	endtask

	// Steady lamps are read directly; blinking ones through the observer
	task automatic pat(input logic l, input int h, input int lo, input int eh, input int el);
		if (eh == 0)
			chk(32'(l), 32'h0);
		else if (el == 0)
			chk(32'(l), 32'h1);
		else begin
			chk(h, eh);
			if (el > 0)
				chk(lo, el);
		end
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		stop_test();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		apb(8'h00, 1'b0, 32'h0);
		chk(rd, 32'h1);
		apb(8'h04, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(8'h10, 1'b0, 32'h0);
		chk(rd, 32'h10c);
		apb(8'h14, 1'b0, 32'h0);
		chk(er, 32'h1);
		apb(8'h08, 1'b1, 32'hffff);
		chk(er, 32'h1);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			up <= i[0];
			dn <= i[1];
			wt(3);
			chk(l_lnk, i != 0);
		end
		apb(8'h00, 1'b1, 32'h0);
		wt(2);
		chk(l_lnk, 32'h0);
		apb(8'h00, 1'b1, 32'h3);
		wt(2);
		chk({cy, cr}, 32'hffffffff);
		apb(8'h00, 1'b1, 32'h1);
		@(posedge pclk);
		rdy <= 1'b1;
		s_ok <= 1'b1;
		a_ok <= 1'b1;
		wt(3);
		chk({r_r, r_y, r_g, u_r, u_g, d_g}, 32'h0b);
		apb(8'h08, 1'b0, 32'h0);
		chk(rd, 32'h143);
		@(posedge pclk);
		fw <= 1'b1;
		wt(200);
		chk({r_r, r_g, 6'(yel_hi), 6'(yel_lo)}, {2'b00, 6'(4*TK), 6'(4*TK)});
		@(posedge pclk);
		tmp <= 1'b1;
		wt(3);
		chk(r_g ^ r_y, 32'h1);
		@(posedge pclk);
		tmp <= 1'b0;
		s_rng <= 1'b1;
		wt(3);
		chk(r_g ^ r_y, 32'h1);
		@(posedge pclk);
		s_rng <= 1'b0;
		s_ovl <= 1'b1;
		a_ok <= 1'b0;
		wt(50);
		chk({r_g ^ r_y, u_r, u_g, d_g}, 32'hc);
		@(posedge pclk);
		{s_ovl, fw, s_ok, rdy} <= 4'h0;
		wt(3);
		chk({r_r, r_y, r_g, u_g}, 32'h0);
		for (int i = 0; i < 5; i++) begin
			@(posedge pclk);
			esm <= RC[i];
			wt(520);
			pat(l_run, run_hi, run_lo, RH[i], RL[i]);
		end
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			{crit, wd, cfg, app} <= FV[i];
			wt(520);
			pat(l_flt, flt_hi, flt_lo, FH[i], FL[i]);
		end
		apb(8'h04, 1'b1, 32'h00ff);
		@(posedge pclk);
		cset <= 16'h0f0f;
		cflt <= 16'h0303;
		wt(3);
		chk({cr, cy}, 32'h00030f0c);
		apb(8'h0c, 1'b0, 32'h0);
		chk(rd, 32'h00030f0c);
		@(posedge pclk);
		presetn <= 1'b0;
		sw_u <= 4'ha;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wt(3);
		chk(r_r, 32'h1);
		apb(8'h10, 1'b0, 32'h0);
		chk(rd[8], 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
